// ===== rtl/rcr_pkg.sv
// Constants and types shared by the regulator control register bank
package rcr_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int CYC_PER_MS = CLK_HZ / 1000;
   localparam int T_150_MS = 150;
   localparam int T_100_MS = 100;
   localparam int T_50_MS = 50;
   localparam int CYC_150 = T_150_MS * CYC_PER_MS;
   localparam int CYC_100 = T_100_MS * CYC_PER_MS;
   localparam int CYC_50 = T_50_MS * CYC_PER_MS;
   localparam int CNT_W = 21;

   localparam int NUM_LDO = 5;
   localparam logic [2:0] OFS_REG_A = 3'h0;
   localparam logic [2:0] OFS_REG_B = 3'h1;
   localparam logic [2:0] OFS_REG_C = 3'h2;
   localparam logic [2:0] OFS_REG_D = 3'h3;
   localparam logic [2:0] OFS_REG_E = 3'h4;
   localparam logic [2:0] OFS_CTRL = 3'h5;
   localparam logic [2:0] OFS_ONOFF = 3'h6;
   localparam logic [2:0] OFS_NONE = 3'h7;

   localparam int ASD_BIT = 5;
   localparam int VCODE_W = 5;
   localparam int CTRL_PG_POL = 7;
   localparam int CTRL_RST_POL = 6;
   localparam int CTRL_MON_LSB = 4;
   localparam int CTRL_PGD_LSB = 2;
   localparam int CTRL_RSTD_LSB = 0;
   localparam int ONOFF_B_BIT = 1;
   localparam int GOOD_A_BIT = 0;

   localparam logic [4:0] VCODE_A_HI = 5'h1B;
   localparam logic [4:0] VCODE_A_LO = 5'h07;
   localparam logic [4:0] VCODE_DEFAULT = 5'h00;
   localparam logic [4:0] ONOFF_DEFAULT = 5'h1F;
   localparam logic [7:0] CTRL_DEFAULT = 8'h06;

   localparam logic [4:0] MON_ACDE = 5'h1D;
   localparam logic [4:0] MON_E = 5'h10;
   localparam logic [4:0] MON_C = 5'h04;
   localparam logic [4:0] MON_D = 5'h08;

   // Arbitrary value
   localparam logic [5:0] DEVICE_TYPE_ID = 6'h2A;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   typedef enum logic [4:0] {
      RCR_IDLE = 5'h01,
      RCR_ADDR = 5'h02,
      RCR_REG = 5'h04,
      RCR_WDATA = 5'h08,
      RCR_RDATA = 5'h10
   } rcr_phase_t;
endpackage : rcr_pkg

// ===== rtl/rcr_regulator_control.sv
// Register bank, serial slave and supervisor outputs of the regulator control
module rcr_regulator_control
#(
   parameter int P_CYC_150 = rcr_pkg::CYC_150,
   parameter int P_CYC_100 = rcr_pkg::CYC_100,
   parameter int P_CYC_50 = rcr_pkg::CYC_50,
   parameter logic [5:0] P_DEVICE_TYPE_ID = rcr_pkg::DEVICE_TYPE_ID,
   parameter logic [4:0] P_VCODE_DEFAULT = rcr_pkg::VCODE_DEFAULT,
   parameter logic [4:0] P_ONOFF_DEFAULT = rcr_pkg::ONOFF_DEFAULT
)
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe_n,
   input wire logic i_enable,
   input wire logic i_address_select_input,
   input wire logic i_core_default_select_input,
   input wire logic i_undervoltage_lockout,
   input wire logic i_overtemperature_trip,
   input wire logic [rcr_pkg::NUM_LDO-1:0] i_regulator_good,
   output logic [rcr_pkg::NUM_LDO-1:0] o_regulator_on,
   output logic [rcr_pkg::NUM_LDO-1:0] o_discharge_on,
   output logic [rcr_pkg::VCODE_W-1:0] o_vcode_a,
   output logic [rcr_pkg::VCODE_W-1:0] o_vcode_b,
   output logic [rcr_pkg::VCODE_W-1:0] o_vcode_c,
   output logic [rcr_pkg::VCODE_W-1:0] o_vcode_d,
   output logic [rcr_pkg::VCODE_W-1:0] o_vcode_e,
   output logic o_core_reset_output,
   output logic o_power_good_output
);
   import rcr_pkg::*;

   if (P_CYC_150 < 1 || P_CYC_150 >= (1 << CNT_W) ||
       P_CYC_100 < 1 || P_CYC_100 >= (1 << CNT_W) ||
       P_CYC_50 < 1 || P_CYC_50 >= (1 << CNT_W))
   begin : g_bad_delay
      $error("delay counts must lie between 1 and 2**CNT_W-1");
   end

   typedef struct packed {
      logic start_seen;
      logic as_m;
      logic as_s;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      rcr_phase_t phase;
      logic [2:0] ptr;
      logic [2:0] wr_ptr;
      logic [7:0] wr_data;
      logic wr_tog;
   } rcr_link_t;

   typedef struct packed {
      logic sda_out;
      logic sda_oe_n;
   } rcr_drive_t;

   typedef struct packed {
      logic [1:0] en_p;
      logic [1:0] uv_p;
      logic [1:0] ot_p;
      logic [1:0] vs_p;
      logic [NUM_LDO-1:0] gd_m;
      logic [NUM_LDO-1:0] gd_s;
      logic wr_m;
      logic wr_s;
      logic wr_d;
      logic en_d;
      logic [NUM_LDO-1:0][5:0] set;
      logic [7:0] ctrl;
      logic [NUM_LDO-1:0] onoff;
      logic [CNT_W-1:0] rst_cnt;
      logic [CNT_W-1:0] pg_cnt;
      logic [7:0] rd_hold;
      logic [NUM_LDO-1:0] reg_on;
      logic [NUM_LDO-1:0] dis;
      logic core_rst;
      logic pg;
   } rcr_core_t;

   rcr_link_t link_r;
   rcr_link_t link_nxt;
   rcr_drive_t drv_r;
   rcr_drive_t drv_nxt;
   rcr_core_t core_r;
   rcr_core_t core_nxt;
   logic start_tog_r;
   logic addr_match;
   logic ack_due;

   function automatic logic [CNT_W-1:0] rcr_delay(input logic [1:0] code,
                                                   input logic is_pg);
      logic [CNT_W-1:0] dly;
      dly = '0;
      case (code)
         2'h0: dly = CNT_W'(P_CYC_150);
         2'h1: dly = is_pg ? CNT_W'(P_CYC_100) : CNT_W'(P_CYC_50);
         2'h2: dly = is_pg ? CNT_W'(P_CYC_50) : CNT_W'(P_CYC_100);
         default: dly = '0;
      endcase
      return dly;
   endfunction : rcr_delay

   function automatic logic [NUM_LDO-1:0] rcr_watch(input logic [1:0] sel);
      logic [NUM_LDO-1:0] m;
      m = MON_ACDE;
      case (sel)
         2'h0: m = MON_ACDE;
         2'h1: m = MON_E;
         2'h2: m = MON_C;
         default: m = MON_D;
      endcase
      return m;
   endfunction : rcr_watch

   // Start condition: data falls while the serial clock is high
   always_ff @(negedge i_sda or posedge i_rst)
   begin
      if (i_rst)
         start_tog_r <= 1'b0;
      else if (i_scl)
         start_tog_r <= ~start_tog_r;
   end

   assign addr_match = (link_r.shreg[7:2] == P_DEVICE_TYPE_ID) &&
                       (link_r.shreg[1] == link_r.as_s);

   assign ack_due = (link_r.bitcnt == ACK_SLOT) &&
                    ((link_r.phase == RCR_ADDR && addr_match) ||
                     link_r.phase == RCR_REG ||
                     link_r.phase == RCR_WDATA);

   // Serial receive side, sampled on the rising serial clock
   always_comb
   begin
      link_nxt = link_r;
      link_nxt.as_m = i_address_select_input;
      link_nxt.as_s = link_r.as_m;
      if (start_tog_r != link_r.start_seen)
      begin
         link_nxt.start_seen = start_tog_r;
         link_nxt.phase = RCR_ADDR;
         link_nxt.bitcnt = 4'h1;
         link_nxt.shreg = {link_r.shreg[6:0], i_sda};
      end
      else
      begin
         case (link_r.phase)
            RCR_ADDR, RCR_REG, RCR_WDATA:
            begin
               if (link_r.bitcnt != ACK_SLOT)
               begin
                  link_nxt.shreg = {link_r.shreg[6:0], i_sda};
                  link_nxt.bitcnt = link_r.bitcnt + 4'h1;
               end
               else
               begin
                  link_nxt.bitcnt = 4'h0;
                  link_nxt.phase = RCR_IDLE;
                  if (link_r.phase == RCR_ADDR && addr_match)
                  begin
                     if (link_r.shreg[0])
                     begin
                        link_nxt.phase = RCR_RDATA;
                        link_nxt.shreg = core_r.rd_hold;
                     end
                     else
                        link_nxt.phase = RCR_REG;
                  end
                  else if (link_r.phase == RCR_REG)
                  begin
                     link_nxt.phase = RCR_WDATA;
                     link_nxt.ptr = (link_r.shreg[7:3] == 5'h00 &&
                                     link_r.shreg[2:0] != OFS_NONE) ?
                                    link_r.shreg[2:0] : OFS_NONE;
                  end
                  else if (link_r.phase == RCR_WDATA)
                  begin
                     // Commit only once the data byte is acknowledged
                     link_nxt.wr_ptr = link_r.ptr;
                     link_nxt.wr_data = link_r.shreg;
                     link_nxt.wr_tog = ~link_r.wr_tog;
                  end
               end
            end
            RCR_RDATA:
            begin
               if (link_r.bitcnt != ACK_SLOT)
               begin
                  link_nxt.shreg = {link_r.shreg[6:0], 1'b0};
                  link_nxt.bitcnt = link_r.bitcnt + 4'h1;
               end
               else
               begin
                  link_nxt.bitcnt = 4'h0;
                  link_nxt.phase = RCR_IDLE;
               end
            end
            default:
            begin
               link_nxt.phase = RCR_IDLE;
               link_nxt.bitcnt = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge i_scl or posedge i_rst)
   begin
      if (i_rst)
         link_r <= '{start_seen: 1'b0, as_m: 1'b0, as_s: 1'b0,
                     bitcnt: 4'h0, shreg: 8'h00, phase: RCR_IDLE,
                     ptr: OFS_NONE, wr_ptr: OFS_NONE, wr_data: 8'h00,
                     wr_tog: 1'b0};
      else
         link_r <= link_nxt;
   end

   // Data line drive, changed on the falling serial clock
   always_comb
   begin
      drv_nxt.sda_out = 1'b0;
      drv_nxt.sda_oe_n = 1'b1;
      if (ack_due)
         drv_nxt.sda_oe_n = 1'b0;
      else if (link_r.phase == RCR_RDATA && link_r.bitcnt != ACK_SLOT)
         drv_nxt.sda_oe_n = link_r.shreg[7];
   end

   always_ff @(negedge i_scl or posedge i_rst)
   begin
      if (i_rst)
         drv_r <= '{sda_out: 1'b0, sda_oe_n: 1'b1};
      else
         drv_r <= drv_nxt;
   end

   // Register bank and supervisor outputs on the reference clock
   always_comb
   begin
      logic en;
      logic fail_a;
      logic fail_pg;
      logic act_a;
      logic act_pg;
      logic [NUM_LDO-1:0] run;
      en = core_r.en_p[1];
      fail_a = 1'b0;
      fail_pg = 1'b0;
      act_a = 1'b0;
      act_pg = 1'b0;
      run = '0;
      core_nxt = core_r;
      core_nxt.en_p = {core_r.en_p[0], i_enable};
      core_nxt.uv_p = {core_r.uv_p[0], i_undervoltage_lockout};
      core_nxt.ot_p = {core_r.ot_p[0], i_overtemperature_trip};
      core_nxt.vs_p = {core_r.vs_p[0], i_core_default_select_input};
      core_nxt.gd_m = i_regulator_good;
      core_nxt.gd_s = core_r.gd_m;
      core_nxt.wr_m = link_r.wr_tog;
      core_nxt.wr_s = core_r.wr_m;
      core_nxt.wr_d = core_r.wr_s;
      core_nxt.en_d = en;
      if (!en)
      begin
         core_nxt.set = '0;
         core_nxt.ctrl = 8'h00;
         core_nxt.onoff = '0;
      end
      else if (!core_r.en_d)
      begin
         for (int i = 0; i < NUM_LDO; i++)
            core_nxt.set[i] = {1'b1, P_VCODE_DEFAULT};
         core_nxt.set[OFS_REG_A] = {1'b1, core_r.vs_p[1] ?
                                   VCODE_A_HI : VCODE_A_LO};
         core_nxt.ctrl = CTRL_DEFAULT;
         core_nxt.onoff = P_ONOFF_DEFAULT;
      end
      else if (core_r.wr_s != core_r.wr_d)
      begin
         case (link_r.wr_ptr)
            OFS_REG_A, OFS_REG_B, OFS_REG_C, OFS_REG_D, OFS_REG_E:
               core_nxt.set[link_r.wr_ptr] = link_r.wr_data[5:0];
            OFS_CTRL:
               core_nxt.ctrl = link_r.wr_data;
            OFS_ONOFF:
               core_nxt.onoff = link_r.wr_data[NUM_LDO-1:0];
            default:
               core_nxt.ctrl = core_r.ctrl;
         endcase
      end
      // Pointer is stable for a whole byte before the read slot uses this
      case (link_r.ptr)
         OFS_REG_A, OFS_REG_B, OFS_REG_C, OFS_REG_D, OFS_REG_E:
            core_nxt.rd_hold = {2'b00, core_r.set[link_r.ptr]};
         OFS_CTRL:
            core_nxt.rd_hold = core_r.ctrl;
         OFS_ONOFF:
            core_nxt.rd_hold = {3'b000, core_r.onoff};
         default:
            core_nxt.rd_hold = 8'h00;
      endcase
      // Settings are kept through lockout, so outputs resume afterwards
      run = core_r.onoff & {NUM_LDO{en & ~core_r.uv_p[1] &
                                   ~core_r.ot_p[1]}};
      core_nxt.reg_on = run;
      for (int i = 0; i < NUM_LDO; i++)
         core_nxt.dis[i] = core_r.set[i][ASD_BIT] & ~run[i];
      fail_a = ~core_r.gd_s[GOOD_A_BIT];
      if (fail_a)
         core_nxt.rst_cnt = rcr_delay(
            core_r.ctrl[CTRL_RSTD_LSB +: 2], 1'b0);
      else if (core_r.rst_cnt != '0)
         core_nxt.rst_cnt = core_r.rst_cnt - CNT_W'(1);
      act_a = fail_a || core_r.rst_cnt != '0;
      fail_pg = |(rcr_watch(core_r.ctrl[CTRL_MON_LSB +: 2]) &
                  ~core_r.gd_s);
      if (fail_pg)
         core_nxt.pg_cnt = rcr_delay(
            core_r.ctrl[CTRL_PGD_LSB +: 2], 1'b1);
      else if (core_r.pg_cnt != '0)
         core_nxt.pg_cnt = core_r.pg_cnt - CNT_W'(1);
      act_pg = fail_pg || core_r.pg_cnt != '0;
      if (core_r.reg_on[ONOFF_B_BIT])
      begin
         core_nxt.core_rst = act_a ^ core_r.ctrl[CTRL_RST_POL];
         core_nxt.pg = act_pg ^ core_r.ctrl[CTRL_PG_POL];
      end
      else
      begin
         core_nxt.core_rst = 1'b0;
         core_nxt.pg = 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         core_r <= '0;
      else
         core_r <= core_nxt;
   end

   assign o_sda_out = drv_r.sda_out;
   assign o_sda_oe_n = drv_r.sda_oe_n;
   assign o_regulator_on = core_r.reg_on;
   assign o_discharge_on = core_r.dis;
   assign o_vcode_a = core_r.set[OFS_REG_A][VCODE_W-1:0];
   assign o_vcode_b = core_r.set[OFS_REG_B][VCODE_W-1:0];
   assign o_vcode_c = core_r.set[OFS_REG_C][VCODE_W-1:0];
   assign o_vcode_d = core_r.set[OFS_REG_D][VCODE_W-1:0];
   assign o_vcode_e = core_r.set[OFS_REG_E][VCODE_W-1:0];
   assign o_core_reset_output = core_r.core_rst;
   assign o_power_good_output = core_r.pg;
endmodule : rcr_regulator_control

// ===== sim/rcr_i2c_master.sv
// Serial bus master model that stands on the far side of the link
module rcr_i2c_master
(
   output logic o_scl,
   output logic o_sda_low,
   input wire logic i_sda
);
   timeunit 1ns;
   timeprecision 1ps;
   int stretch = 0;
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // One bit slot; a released line reads the bus level
   task automatic bit_io(input logic b, output logic r);
      o_sda_low = !b;
      #(70 + stretch) o_scl = 1'b1;
      #40 r = i_sda;
      #40 o_scl = 1'b0;
      #10;
   endtask : bit_io
   task automatic start_cond;
      o_sda_low = 1'b0;
      #40 o_scl = 1'b1;
      #80 o_sda_low = 1'b1;
      #80 o_scl = 1'b0;
      #10;
   endtask : start_cond
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
                       output logic nack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bit_io(tx[i], r);
         rx[i] = r;
      end
      bit_io(1'b1, nack);
   endtask : xfer
   // Whole frame; ok is high when every address, register and written data byte was acked
   task automatic access(input logic asel, input logic is_rd,
                         input logic [7:0] ra, input logic [7:0] wd,
                         output logic [7:0] rdat, output logic ok);
      logic [7:0] d;
      logic a1, a2, a3, a4;
      #13 start_cond;
      xfer({rcr_pkg::DEVICE_TYPE_ID, asel, 1'b0}, d, a1);
      xfer(ra, d, a2);
      if (is_rd)
      begin
         start_cond;
         xfer({rcr_pkg::DEVICE_TYPE_ID, asel, 1'b1}, d, a3);
         xfer(8'hFF, rdat, a4);
      end
      else
         xfer(wd, rdat, a3);
      o_sda_low = 1'b1;
      #70 o_scl = 1'b1;
      #80 o_sda_low = 1'b0;
      #80;
      ok = !a1 && !a2 && !a3;
   endtask : access
endmodule : rcr_i2c_master

// ===== sim/rcr_regulator_control_chk.sv
// Checker for the regulator control register bank outputs
module rcr_regulator_control_chk
(
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic i_undervoltage_lockout,
   input wire logic i_overtemperature_trip,
   input wire logic [rcr_pkg::NUM_LDO-1:0] i_regulator_good,
   input wire logic [rcr_pkg::NUM_LDO-1:0] o_regulator_on,
   input wire logic [rcr_pkg::NUM_LDO-1:0] o_discharge_on,
   input wire logic [rcr_pkg::VCODE_W-1:0] o_vcode_a,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic o_core_reset_output,
   input wire logic o_power_good_output
);
   timeunit 1ns;
   timeprecision 1ps;
   import rcr_pkg::*;
   logic [5:0] cnt_r;
   logic rel_r;
   logic rel_ok_r;
   logic steady;
   assign steady = i_regulator_good[GOOD_A_BIT] && o_regulator_on[ONOFF_B_BIT];
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // Learn the released reset level after a long steady spell
   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst || !steady)
         cnt_r <= 6'h00;
      else if (cnt_r != 6'h3F)
         cnt_r <= cnt_r + 6'h01;
      if (i_rst)
         rel_ok_r <= 1'b0;
      else if (cnt_r > 6'h30)
         rel_ok_r <= 1'b1;
      if (cnt_r > 6'h30)
         rel_r <= o_core_reset_output;
   end
   uv_off_a: assert property (
      i_undervoltage_lockout [*5] |-> o_regulator_on == 5'h00)
      else $error("regulator on during undervoltage");
   ot_off_a: assert property (
      i_overtemperature_trip [*5] |-> o_regulator_on == 5'h00)
      else $error("regulator on during overtemperature");
   en_clear_a: assert property (
      !i_enable [*7] |-> (o_regulator_on | o_discharge_on) == 5'h00
      && o_vcode_a == 5'h00) else $error("state kept while disabled");
   discharge_off_a: assert property (
      $stable(o_regulator_on) && $stable(o_discharge_on)
      |-> (o_regulator_on & o_discharge_on) == 5'h00)
      else $error("discharge on a running regulator");
   b_off_quiet_a: assert property (
      !o_regulator_on[ONOFF_B_BIT] [*3] |-> !o_core_reset_output
      && !o_power_good_output) else $error("supervisor active, B off");
   rst_assert_a: assert property (
      (rel_ok_r && !i_regulator_good[GOOD_A_BIT]
      && o_regulator_on[ONOFF_B_BIT]) [*4] |-> o_core_reset_output != rel_r)
      else $error("reset output not asserted");
   rst_release_a: assert property (
      rel_ok_r && cnt_r == 6'h28 |-> o_core_reset_output == rel_r)
      else $error("reset output not released in time");
   sda_low_a: assert property (
      !o_sda_oe_n |-> !o_sda_out) else $error("data line driven high");
   cover property (i_undervoltage_lockout [*5]);
   cover property (!i_enable [*7]);
   cover property (rel_ok_r && !i_regulator_good[GOOD_A_BIT] ##1 steady);
endmodule : rcr_regulator_control_chk
bind rcr_regulator_control rcr_regulator_control_chk chk
(
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_enable(i_enable),
   .i_undervoltage_lockout(i_undervoltage_lockout),
   .i_overtemperature_trip(i_overtemperature_trip),
   .i_regulator_good(i_regulator_good), .o_regulator_on(o_regulator_on),
   .o_discharge_on(o_discharge_on), .o_vcode_a(o_vcode_a),
   .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
   .o_core_reset_output(o_core_reset_output),
   .o_power_good_output(o_power_good_output)
);

// ===== sim/test_rcr_regulator_control.sv
// Self-checking bench for the regulator control register bank
module test_rcr_regulator_control;
   timeunit 1ns;
   timeprecision 1ps;
   import rcr_pkg::*;
   logic ref_clk = 1'b0;
   logic rst, scl, sda_low, sda, sda_out, sda_oe_n, en, asel, vsel, uv, ot;
   logic [4:0] good, reg_on, dis_on, va, vb, vc, vd, ve;
   logic rst_out, pg_out, ack;
   logic [7:0] rd;
   int n_mismatch = 0;
   int checked = 0;
   always #50 ref_clk = !ref_clk;
   assign sda = (sda_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
   rcr_regulator_control #(.P_CYC_150(30), .P_CYC_100(20), .P_CYC_50(10)) dut
   (
      .i_ref_clk(ref_clk), .i_rst(rst), .i_scl(scl), .i_sda(sda),
      .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_enable(en),
      .i_address_select_input(asel), .i_core_default_select_input(vsel),
      .i_undervoltage_lockout(uv), .i_overtemperature_trip(ot),
      .i_regulator_good(good), .o_regulator_on(reg_on),
      .o_discharge_on(dis_on), .o_vcode_a(va), .o_vcode_b(vb),
      .o_vcode_c(vc), .o_vcode_d(vd), .o_vcode_e(ve),
      .o_core_reset_output(rst_out), .o_power_good_output(pg_out)
   );
   rcr_i2c_master m (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
   task automatic end_of_test;
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cyc
   task automatic chk(input string nm, input logic [7:0] exp,
                      input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [2:0] ra, input logic [7:0] wd);
      m.access(asel, 1'b0, {5'h00, ra}, wd, rd, ack);
      chk("write_ack", 8'h01, {7'h00, ack});
      cyc(10);
   endtask : wr
   task automatic rdr(input logic [2:0] ra, input logic [7:0] exp,
                      input string nm);
      m.access(asel, 1'b1, {5'h00, ra}, 8'h00, rd, ack);
      chk(nm, exp, rd);
   endtask : rdr
   // Fault one good input, then time the release of both outputs
   task automatic pulse(input int b, input int d);
      int n = 0;
      good[b] <= 1'b0;
      cyc(6);
      chk("fault", 8'h01, {7'h00, rst_out | pg_out});
      good[b] <= 1'b1;
      while ((rst_out | pg_out) === 1'b1 && n < 200)
      begin
         cyc(1);
         n++;
      end
      chk("delay", 8'h01, {7'h00, n >= d && n <= d + 5});
   endtask : pulse
   initial
   begin
      #5_000_000;
      n_mismatch++;
      end_of_test;
   end
   initial
   begin
      rst = 1'b1;
      en = 1'b0;
      asel = 1'b0;
      vsel = 1'b1;
      uv = 1'b0;
      ot = 1'b0;
      good = 5'h1F;
      cyc(2);
      rst <= 1'b0;
      en <= 1'b1;
      cyc(10);
      rdr(OFS_REG_A, 8'h3B, "reg_a");
      rdr(OFS_CTRL, 8'h06, "ctrl");
      rdr(OFS_ONOFF, 8'h1F, "onoff");
      rdr(OFS_NONE, 8'h00, "unmapped");
      chk("vcode_a", 8'h1B, {3'h0, va});
      wr(OFS_REG_C, 8'hD5);
      rdr(OFS_REG_C, 8'h15, "reg_c");
      chk("vcode_c", 8'h15, {3'h0, vc});
      wr(OFS_REG_B, 8'h31);
      wr(OFS_REG_D, 8'h2A);
      wr(OFS_REG_E, 8'hFF);
      chk("vcode_b", 8'h11, {3'h0, vb});
      chk("vcode_d", 8'h0A, {3'h0, vd});
      chk("vcode_e", 8'h1F, {3'h0, ve});
      wr(OFS_ONOFF, 8'hE2);
      chk("on", 8'h02, {3'h0, reg_on});
      chk("discharge", 8'h19, {3'h0, dis_on});
      wr(OFS_ONOFF, 8'h1D);
      chk("quiet", 8'h00, {6'h00, rst_out, pg_out});
      wr(OFS_ONOFF, 8'h1F);
      chk("vcode_kept", 8'h15, {3'h0, vc});
      m.access(!asel, 1'b0, 8'h02, 8'h01, rd, ack);
      chk("refused", 8'h00, {7'h00, ack});
      cyc(1);
      asel <= 1'b1;
      cyc(2);
      rdr(OFS_REG_C, 8'h15, "reg_c_asel");
      for (int k = 0; k < 4; k++)
      begin
         wr(OFS_CTRL, 8'h0C | 8'(k));
         cyc(50);
         pulse(0, k == 0 ? 30 : k == 1 ? 10 : k == 2 ? 20 : 0);
      end
      chk("polarity", 8'h00, {6'h00, rst_out, pg_out});
      wr(OFS_CTRL, 8'hCC);
      cyc(50);
      chk("inverted", 8'h03, {6'h00, rst_out, pg_out});
      wr(OFS_ONOFF, 8'h1D);
      chk("quiet_inv", 8'h00, {6'h00, rst_out, pg_out});
      wr(OFS_ONOFF, 8'h1F);
      cyc(50);
      wr(OFS_CTRL, 8'h1C);
      good[2] <= 1'b0;
      cyc(6);
      chk("unwatched", 8'h00, {7'h00, pg_out});
      good[2] <= 1'b1;
      wr(OFS_CTRL, 8'h17);
      pulse(4, 20);
      wr(OFS_CTRL, 8'h28);
      pulse(2, 10);
      wr(OFS_CTRL, 8'h30);
      pulse(3, 30);
      for (int k = 0; k < 2; k++)
      begin
         if (k == 0)
            uv <= 1'b1;
         else
            ot <= 1'b1;
         cyc(8);
         chk("trip_off", 8'h00, {3'h0, reg_on});
         uv <= 1'b0;
         ot <= 1'b0;
         cyc(8);
         chk("trip_back", 8'h1F, {3'h0, reg_on});
      end
      ot <= 1'b1;
      cyc(8);
      en <= 1'b0;
      cyc(8);
      ot <= 1'b0;
      vsel <= 1'b0;
      cyc(8);
      chk("shut", 8'h00, {3'h0, reg_on});
      chk("cleared", 8'h00, {3'h0, vc});
      chk("cleared_e", 8'h00, {3'h0, ve});
      en <= 1'b1;
      cyc(10);
      chk("vcode_a_lo", 8'h07, {3'h0, va});
      chk("vcode_e_dflt", {3'h0, VCODE_DEFAULT}, {3'h0, ve});
      m.stretch = 400;
      rdr(OFS_REG_C, 8'h20, "reg_c_default");
      end_of_test;
   end
endmodule : test_rcr_regulator_control
